// File: hdl/arlc_pkg.sv
// Constants, register map and types for the redriver lane-control block.
// Assumes a single 50 MHz clock domain and a synchronous active-low reset.
package arlc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int DEBOUNCE_MIN_MS = 3;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MIN_MS;
  localparam int SBU_OPEN_MS = 2;
  localparam int SBU_OPEN_CYC = CLK_HZ / 1000 * SBU_OPEN_MS;
  localparam int STRAP_HOLD_NS = 1000;
  localparam int STRAP_HOLD_CYC = (STRAP_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int U2_IDLE_US = 100;
  localparam int U2_IDLE_CYC = U2_IDLE_US * CLK_MHZ;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CFG_REG_OFF = 8'h0a;
  localparam logic [7:0] LANE_REG_OFF = 8'h0b;
  localparam logic [7:0] UPG1_REG_OFF = 8'h0c;
  localparam logic [7:0] UPG2_REG_OFF = 8'h0d;
  localparam logic [7:0] DNG_REG_OFF = 8'h0e;
  localparam logic [7:0] DPG_REG_OFF = 8'h0f;
  localparam logic [7:0] SNOOP_REG_OFF = 8'h12;
  localparam logic [7:0] CTRL_REG_OFF = 8'h13;

  localparam int CFG_USB_BIT = 0;
  localparam int CFG_DISP_BIT = 1;
  localparam int CFG_FLIP_BIT = 2;
  localparam int CFG_OVR_LSB = 3;
  localparam logic [7:0] CFG_RST = 8'h01;
  localparam logic [3:0] LANE_RST = 4'hf;
  localparam int CTRL_SNOOP_OFF_BIT = 0;
  localparam int SNP_LANE_LSB = 0;
  localparam int SNP_PWR_LSB = 5;

  // Sink-side addresses and values watched on the aux channel; sideband override codes
  localparam logic [19:0] DPCD_LANE_ADDR = 20'h00101;
  localparam logic [19:0] DPCD_PWR_ADDR = 20'h00600;
  localparam logic [2:0] PWR_D3 = 3'h2;
  localparam logic [1:0] OVR_AUTO = 2'h0;
  localparam logic [1:0] OVR_STRAIGHT = 2'h1;
  localparam logic [1:0] OVR_CROSSED = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    LVL_0 = 2'b00,
    LVL_R = 2'b01,
    LVL_F = 2'b10,
    LVL_1 = 2'b11
  } arlc_level_t;

  // Encoded as {display, usb}
  typedef enum logic [1:0] {
    CFG_OFF = 2'b00,
    CFG_USB = 2'b01,
    CFG_DP4 = 2'b10,
    CFG_USB_DP2 = 2'b11
  } arlc_cfg_t;

  typedef enum logic [1:0] {
    U0 = 2'b00,
    U1 = 2'b01,
    U2 = 2'b10,
    U3 = 2'b11
  } arlc_ustate_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] up;
    logic [3:0] dn;
    logic [3:0] dp;
  } arlc_strap_t;

  typedef struct packed {
    logic up_on;
    logic dn_on;
    logic [3:0] up1;
    logic [3:0] up2;
    logic [3:0] dn;
    logic [3:0] dp;
  } arlc_eq_t;

  typedef struct packed {
    logic a_to_n;
    logic a_to_p;
    logic b_to_n;
    logic b_to_p;
  } arlc_sbu_t;

endpackage : arlc_pkg

// File: hdl/arlc_pin_filter.sv
// Three-stage pin synchroniser with optional debounce of falling edges.
// Assumes pin is asynchronous to clk; level_q is a clean clk-domain level.
`timescale 1ns/100ps
module arlc_pin_filter #(
  parameter int FALL_CYC = 0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level_q
);
  localparam int CW = $clog2(FALL_CYC + 2);
  localparam logic [CW-1:0] FALL_LIM = CW'(FALL_CYC);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic [CW-1:0] cnt_q;

  generate
    if (FALL_CYC < 0) begin : g_bad
      $error("arlc_pin_filter: FALL_CYC must not be negative");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Rises pass at once; falls must stay agreed low for FALL_CYC cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_q <= 1'b0;
      cnt_q <= '0;
    end else if (s2_q != s3_q) begin
      cnt_q <= '0;
    end else if (s3_q || cnt_q >= FALL_LIM) begin
      level_q <= s3_q;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule : arlc_pin_filter

// File: hdl/arlc_top.sv
// Lane, sideband and equalisation control of a sink-side alt-mode redriver.
// Assumes aux writes arrive already decoded on clk; pins are asynchronous.
`timescale 1ns/100ps
// Function
// - Infer link power state from line conditions
// - Periodic signalling turns off path equalisation
// - Otherwise equalise from straps or programmed registers
// - Snoop aux writes to lane-count and power addresses
// - Lanes follow latest snooped lane count
// - Snooped D3 power state disables all lanes
// - Snoop on after reset; off uses registers
// - Snooped writes update fields at 0x12
// - Strap mode: no snoop, four lanes (DP4) or two (USB+DP2) on hot-plug
// - Four-level input resolves to 0, R, F, 1
// - Sample straps at reset release, then drop bias
// - Each path takes gain from two straps
// - Mode-select at level 0 means strap mode
// - Two mode pins pick configuration, flip orientation
// - Start in USB-only after power-up
// - Sideband routed by flip, open 2 ms after display off in strap mode, at once in register mode
// - Other mode-select levels mean register mode
// - Levels encode 00, 01, 10, 11
// - Debounce falling display pin and hot-plug
// - Display data needs display mode and hot-plug
module arlc_top
  import arlc_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int SBU_CYC = SBU_OPEN_CYC,
  parameter int HOLD_CYC = STRAP_HOLD_CYC,
  parameter int U2_CYC = U2_IDLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic usb_mode_pin,
  input wire logic display_mode_pin,
  input wire logic flip_pin,
  input wire logic hot_plug_input,
  input wire logic [1:0] mode_sel_level,
  input wire logic [3:0] upstream_gain_straps,
  input wire logic [3:0] downstream_gain_straps,
  input wire logic [3:0] display_gain_straps,
  input wire logic lfps_up,
  input wire logic lfps_dn,
  input wire logic rx_term_det,
  input wire logic elec_idle,
  input wire logic ss_rate_det,
  input wire logic aux_wr_valid,
  input wire logic [19:0] aux_wr_addr,
  input wire logic [7:0] aux_wr_data,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic bias_en_q,
  output logic strap_mode_q,
  output logic usb_en_q,
  output logic flip_q,
  output logic [3:0] dp_lane_en_q,
  output arlc_sbu_t sbu_q,
  output arlc_eq_t eq_q,
  output arlc_ustate_t usb_pstate_q
);

  // ----------------------------------------
  // Elaboration checks and helpers
  // ----------------------------------------
  generate
    if (DEB_CYC < 1 || SBU_CYC < 1 || HOLD_CYC < SYNC_STAGES || U2_CYC < 1) begin : g_bad
      $error("arlc_top: timing parameters out of range");
    end
  endgenerate

  localparam int SW = $clog2(SBU_CYC + 1);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int UW = $clog2(U2_CYC + 1);
  localparam int NA = 7;

  function automatic logic [3:0] lanes_of_cfg(input arlc_cfg_t c);
    case (c)
      CFG_DP4: lanes_of_cfg = 4'hf;
      CFG_USB_DP2: lanes_of_cfg = 4'h3;
      default: lanes_of_cfg = 4'h0;
    endcase
  endfunction : lanes_of_cfg

  function automatic logic [3:0] lanes_of_count(input logic [4:0] n);
    case (n)
      5'h01: lanes_of_count = 4'h1;
      5'h02: lanes_of_count = 4'h3;
      5'h04: lanes_of_count = 4'hf;
      default: lanes_of_count = 4'h0;
    endcase
  endfunction : lanes_of_count

  function automatic arlc_sbu_t sbu_map(input logic crossed);
    sbu_map = crossed ? arlc_sbu_t'(4'b0110) : arlc_sbu_t'(4'b1001);
  endfunction : sbu_map

  // ----------------------------------------
  // Pin conditioning
  // ----------------------------------------
  logic [NA-1:0] raw_pins;
  logic [NA-1:0] pin_f;
  logic disp_f;
  logic hpd_f;
  logic usb_f;
  logic flip_f;
  logic lfps_up_f;
  logic lfps_dn_f;
  logic term_f;
  logic idle_f;
  logic rate_f;

  assign raw_pins = {ss_rate_det, elec_idle, rx_term_det, lfps_dn, lfps_up, flip_pin, usb_mode_pin};
  assign {rate_f, idle_f, term_f, lfps_dn_f, lfps_up_f, flip_f, usb_f} = pin_f;

  generate
    for (genvar i = 0; i < NA; i++) begin : g_pin
      arlc_pin_filter #(.FALL_CYC(0)) u_flt (
        .clk(clk),
        .rst_n(rst_n),
        .pin(raw_pins[i]),
        .level_q(pin_f[i])
      );
    end
  endgenerate

  arlc_pin_filter #(.FALL_CYC(DEB_CYC)) u_disp_flt (
    .clk(clk),
    .rst_n(rst_n),
    .pin(display_mode_pin),
    .level_q(disp_f)
  );

  arlc_pin_filter #(.FALL_CYC(DEB_CYC)) u_hpd_flt (
    .clk(clk),
    .rst_n(rst_n),
    .pin(hot_plug_input),
    .level_q(hpd_f)
  );

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Straps are static, so the three-stage sample only guards metastability
  arlc_strap_t strap_raw;
  arlc_strap_t st1_q;
  arlc_strap_t st2_q;
  arlc_strap_t st3_q;
  arlc_strap_t strap_q;
  logic cap_done_q;
  logic [HW-1:0] hold_cnt_q;

  assign strap_raw = {mode_sel_level, upstream_gain_straps, downstream_gain_straps, display_gain_straps};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st1_q <= '0;
      st2_q <= '0;
      st3_q <= '0;
    end else begin
      st1_q <= strap_raw;
      st2_q <= st1_q;
      st3_q <= st2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_q <= '0;
      cap_done_q <= 1'b0;
      strap_mode_q <= 1'b1;
      hold_cnt_q <= '0;
      bias_en_q <= 1'b1;
    end else begin
      if (hold_cnt_q != HW'(HOLD_CYC)) begin
        hold_cnt_q <= hold_cnt_q + 1'b1;
      end
      if (!cap_done_q && hold_cnt_q >= HW'(SYNC_STAGES) && st2_q == st3_q) begin
        strap_q <= st3_q;
        strap_mode_q <= (arlc_level_t'(st3_q.mode) == LVL_0);
        cap_done_q <= 1'b1;
      end
      if (cap_done_q && hold_cnt_q == HW'(HOLD_CYC)) begin
        bias_en_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] cfg_q;
  logic [3:0] lane_cfg_q;
  logic snoop_off_q;
  logic [3:0] upstream_gain_lane1_reg_q;
  logic [3:0] upstream_gain_lane2_reg_q;
  logic [3:0] downstream_gain_reg_q;
  logic [3:0] dp_gain_reg_q;
  logic [3:0] gain_prog_q;
  logic [4:0] snp_lane_q;
  logic [2:0] snp_pwr_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= CFG_RST;
      lane_cfg_q <= LANE_RST;
      snoop_off_q <= 1'b0;
      upstream_gain_lane1_reg_q <= '0;
      upstream_gain_lane2_reg_q <= '0;
      downstream_gain_reg_q <= '0;
      dp_gain_reg_q <= '0;
      gain_prog_q <= '0;
    end else if (reg_wr_en) begin
      case (reg_addr)
        CFG_REG_OFF: cfg_q <= {3'h0, reg_wdata[4:0]};
        LANE_REG_OFF: lane_cfg_q <= reg_wdata[3:0];
        CTRL_REG_OFF: snoop_off_q <= reg_wdata[CTRL_SNOOP_OFF_BIT];
        UPG1_REG_OFF: {gain_prog_q[0], upstream_gain_lane1_reg_q} <= {1'b1, reg_wdata[3:0]};
        UPG2_REG_OFF: {gain_prog_q[1], upstream_gain_lane2_reg_q} <= {1'b1, reg_wdata[3:0]};
        DNG_REG_OFF: {gain_prog_q[2], downstream_gain_reg_q} <= {1'b1, reg_wdata[3:0]};
        DPG_REG_OFF: {gain_prog_q[3], dp_gain_reg_q} <= {1'b1, reg_wdata[3:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= '0;
    end else begin
      case (reg_addr)
        CFG_REG_OFF: reg_rdata_q <= cfg_q;
        LANE_REG_OFF: reg_rdata_q <= {4'h0, lane_cfg_q};
        CTRL_REG_OFF: reg_rdata_q <= {7'h0, snoop_off_q};
        UPG1_REG_OFF: reg_rdata_q <= {4'h0, upstream_gain_lane1_reg_q};
        UPG2_REG_OFF: reg_rdata_q <= {4'h0, upstream_gain_lane2_reg_q};
        DNG_REG_OFF: reg_rdata_q <= {4'h0, downstream_gain_reg_q};
        DPG_REG_OFF: reg_rdata_q <= {4'h0, dp_gain_reg_q};
        SNOOP_REG_OFF: reg_rdata_q <= {snp_pwr_q, snp_lane_q};
        default: reg_rdata_q <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Configuration select
  // ----------------------------------------
  logic usb_hold_q;
  logic usb_prev_q;
  arlc_cfg_t cfg_cur;
  logic flip_cur;
  logic disp_sel;

  // Power-up default holds until the controller pulses the usb pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      usb_hold_q <= 1'b1;
      usb_prev_q <= 1'b0;
    end else begin
      usb_prev_q <= usb_f;
      if (usb_prev_q && !usb_f) begin
        usb_hold_q <= 1'b0;
      end
    end
  end

  always_comb begin
    if (strap_mode_q) begin
      cfg_cur = usb_hold_q ? CFG_USB : arlc_cfg_t'({disp_f, usb_f});
      flip_cur = flip_f;
    end else begin
      cfg_cur = arlc_cfg_t'({cfg_q[CFG_DISP_BIT], cfg_q[CFG_USB_BIT]});
      flip_cur = cfg_q[CFG_FLIP_BIT];
    end
  end

  assign disp_sel = cfg_cur[1];

  // ----------------------------------------
  // Aux snooping
  // ----------------------------------------
  logic snoop_on;
  logic snp_hit_lane;
  logic snp_hit_pwr;

  assign snoop_on = !strap_mode_q && !snoop_off_q && disp_sel;
  assign snp_hit_lane = snoop_on && aux_wr_valid && aux_wr_addr == DPCD_LANE_ADDR;
  assign snp_hit_pwr = snoop_on && aux_wr_valid && aux_wr_addr == DPCD_PWR_ADDR;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snp_lane_q <= '0;
      snp_pwr_q <= '0;
    end else begin
      if (snp_hit_lane) begin
        snp_lane_q <= aux_wr_data[SNP_LANE_LSB +: 5];
      end
      if (snp_hit_pwr) begin
        snp_pwr_q <= aux_wr_data[2:0];
      end
    end
  end

  // ----------------------------------------
  // Lane enables and path outputs
  // ----------------------------------------
  logic [3:0] lanes_prov;
  logic [3:0] lane_d;

  assign lanes_prov = lanes_of_cfg(cfg_cur);

  always_comb begin
    if (!hpd_f) begin
      lane_d = 4'h0;
    end else if (strap_mode_q) begin
      lane_d = lanes_prov;
    end else if (!snoop_on) begin
      lane_d = lane_cfg_q & lanes_prov;
    end else if (snp_pwr_q == PWR_D3) begin
      lane_d = 4'h0;
    end else begin
      lane_d = lanes_of_count(snp_lane_q) & lanes_prov;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dp_lane_en_q <= '0;
      usb_en_q <= 1'b0;
      flip_q <= 1'b0;
    end else begin
      dp_lane_en_q <= lane_d;
      usb_en_q <= cfg_cur[0];
      flip_q <= flip_cur;
    end
  end

  // ----------------------------------------
  // Sideband routing
  // ----------------------------------------
  logic [SW-1:0] off_cnt_q;
  logic [1:0] ovr;

  assign ovr = cfg_q[CFG_OVR_LSB +: 2];

  // In strap mode, open only once display has stayed off long enough; register mode opens at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      off_cnt_q <= '0;
      sbu_q <= '0;
    end else begin
      if (disp_sel) begin
        off_cnt_q <= '0;
      end else if (off_cnt_q != SW'(SBU_CYC)) begin
        off_cnt_q <= off_cnt_q + 1'b1;
      end
      if (!strap_mode_q && ovr == OVR_STRAIGHT) begin
        sbu_q <= sbu_map(1'b0);
      end else if (!strap_mode_q && ovr == OVR_CROSSED) begin
        sbu_q <= sbu_map(1'b1);
      end else if (!strap_mode_q && ovr != OVR_AUTO) begin
        sbu_q <= '0;
      end else if (disp_sel) begin
        sbu_q <= sbu_map(flip_cur);
      end else if (!strap_mode_q || off_cnt_q == SW'(SBU_CYC)) begin
        sbu_q <= '0;
      end
    end
  end

  // ----------------------------------------
  // Equalisation
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eq_q <= '0;
    end else begin
      eq_q.up_on <= !lfps_up_f;
      eq_q.dn_on <= !lfps_dn_f;
      eq_q.up1 <= gain_prog_q[0] ? upstream_gain_lane1_reg_q : strap_q.up;
      eq_q.up2 <= gain_prog_q[1] ? upstream_gain_lane2_reg_q : strap_q.up;
      eq_q.dn <= gain_prog_q[2] ? downstream_gain_reg_q : strap_q.dn;
      eq_q.dp <= gain_prog_q[3] ? dp_gain_reg_q : strap_q.dp;
    end
  end

  // ----------------------------------------
  // Link power-state inference
  // ----------------------------------------
  logic [UW-1:0] idle_cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      usb_pstate_q <= U3;
      idle_cnt_q <= '0;
    end else begin
      if (!idle_f) begin
        idle_cnt_q <= '0;
      end else if (idle_cnt_q != UW'(U2_CYC)) begin
        idle_cnt_q <= idle_cnt_q + 1'b1;
      end
      case (usb_pstate_q)
        U0, U1, U2: begin
          if (!term_f) begin
            usb_pstate_q <= U3;
          end else if (!idle_f && rate_f) begin
            usb_pstate_q <= U0;
          end else if (idle_f && !lfps_up_f) begin
            usb_pstate_q <= (idle_cnt_q == UW'(U2_CYC)) ? U2 : U1;
          end
        end
        U3: begin
          if (term_f && !idle_f && rate_f) begin
            usb_pstate_q <= U0;
          end
        end
        default: usb_pstate_q <= U3;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_lfps_eq_off: assert property (lfps_up_f |=> !eq_q.up_on)
    else $error("equalisation on during periodic signalling");
  a_eq_strap_gain: assert property (!gain_prog_q[2] |=> eq_q.dn == $past(strap_q.dn))
    else $error("downstream gain not from strap");
  a_snoop_lane_upd: assert property (snp_hit_lane |=> snp_lane_q == $past(aux_wr_data[4:0]))
    else $error("snooped lane count not captured");
  a_d3_lanes_off: assert property (snoop_on && snp_pwr_q == PWR_D3 ##1 snoop_on |-> dp_lane_en_q == 4'h0)
    else $error("lanes active in D3");
  a_strap_four_lanes: assert property (strap_mode_q && hpd_f && cfg_cur == CFG_DP4 |=> dp_lane_en_q == 4'hf)
    else $error("strap mode lanes wrong");
  a_hpd_gates_lanes: assert property (!hpd_f |=> dp_lane_en_q == 4'h0)
    else $error("lanes on without hot-plug");
  a_straps_stable: assert property (cap_done_q |=> $stable(strap_q) && $stable(strap_mode_q))
    else $error("straps changed after capture");
  a_bias_after_cap: assert property ($fell(bias_en_q) |-> cap_done_q && $past(cap_done_q))
    else $error("bias dropped before capture");
  a_usb_first: assert property (strap_mode_q && usb_hold_q |=> usb_en_q && dp_lane_en_q == 4'h0)
    else $error("not usb-only after power-up");
  a_sbu_flip: assert property (strap_mode_q && disp_sel && flip_cur |=> sbu_q == sbu_map(1'b1))
    else $error("sideband not crossed with flip");
  a_pstate_u0: assert property (term_f && !idle_f && rate_f |=> usb_pstate_q == U0)
    else $error("active link not shown as U0");

  c_snoop_two_lanes: cover property (snp_hit_lane ##1 dp_lane_en_q == 4'h3);
  c_sbu_open: cover property (strap_mode_q && !disp_sel ##1 sbu_q == 4'h0);
  c_usb_release: cover property ($fell(usb_hold_q));
  c_pstate_u2: cover property (usb_pstate_q == U2);

endmodule : arlc_top

// File: verif/arlc_pd_model.sv
// Model of the PD controller and display source: mode pins, hot-plug, aux writes.
// Assumes its tasks are called from one bench process; changes land on clk rising edges.
`timescale 1ns/100ps
module arlc_pd_model (
  input wire logic clk,
  output logic usb_mode_pin,
  output logic display_mode_pin,
  output logic flip_pin,
  output logic hot_plug_input,
  output logic aux_wr_valid,
  output logic [19:0] aux_wr_addr,
  output logic [7:0] aux_wr_data
);
  initial begin
    {usb_mode_pin, display_mode_pin, flip_pin, hot_plug_input, aux_wr_valid} = 5'h00;
    aux_wr_addr = 20'h00000;
    aux_wr_data = 8'h00;
  end

  task automatic set_pins(input logic u, input logic d, input logic f, input logic h);
    @(posedge clk);
    usb_mode_pin <= u;
    display_mode_pin <= d;
    flip_pin <= f;
    hot_plug_input <= h;
  endtask : set_pins

  // High then low on the usb pin, long enough to pass the synchroniser
  task automatic leave_usb();
    set_pins(1'b1, display_mode_pin, flip_pin, hot_plug_input);
    repeat (8) @(posedge clk);
    set_pins(1'b0, display_mode_pin, flip_pin, hot_plug_input);
  endtask : leave_usb

  // Writes arrive already framed by the source's sync patterns
  task automatic aux_write(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    aux_wr_valid <= 1'b1;
    aux_wr_addr <= a;
    aux_wr_data <= d;
    @(posedge clk);
    aux_wr_valid <= 1'b0;
    // Released lines do not keep the last value
    aux_wr_addr <= ~a;
    aux_wr_data <= ~d;
  endtask : aux_write
endmodule : arlc_pd_model

// File: verif/arlc_top_tb.sv
// Self-checking bench for the redriver lane-control block.
// Assumes shortened debounce, sideband and hold counts set below.
`timescale 1ns/100ps
module arlc_top_tb;
  import arlc_pkg::*;
  logic clk, rst_n, lfps_up, lfps_dn, rx_term_det, elec_idle, ss_rate_det, reg_wr_en;
  logic usb_mode_pin, display_mode_pin, flip_pin, hot_plug_input, aux_wr_valid;
  logic [19:0] aux_wr_addr;
  logic [7:0] aux_wr_data, reg_addr, reg_wdata, reg_rdata_q;
  logic [1:0] mode_sel_level;
  logic [3:0] upstream_gain_straps, downstream_gain_straps, display_gain_straps, dp_lane_en_q;
  logic bias_en_q, strap_mode_q, usb_en_q, flip_q;
  arlc_sbu_t sbu_q;
  arlc_eq_t eq_q;
  arlc_ustate_t usb_pstate_q;
  int n_fail = 0;
  int checks = 0;
  logic [7:0] lc [3] = '{8'h01, 8'h02, 8'h04};
  logic [3:0] le [3] = '{4'h1, 4'h3, 4'hf};

  arlc_pd_model u_arlc_pd_model (.clk(clk), .usb_mode_pin(usb_mode_pin), .display_mode_pin(display_mode_pin),
    .flip_pin(flip_pin), .hot_plug_input(hot_plug_input), .aux_wr_valid(aux_wr_valid),
    .aux_wr_addr(aux_wr_addr), .aux_wr_data(aux_wr_data));
  arlc_top #(.DEB_CYC(8), .SBU_CYC(8), .HOLD_CYC(6), .U2_CYC(8)) u_arlc_top (.clk(clk), .rst_n(rst_n),
    .usb_mode_pin(usb_mode_pin), .display_mode_pin(display_mode_pin), .flip_pin(flip_pin),
    .hot_plug_input(hot_plug_input), .mode_sel_level(mode_sel_level),
    .upstream_gain_straps(upstream_gain_straps), .downstream_gain_straps(downstream_gain_straps),
    .display_gain_straps(display_gain_straps), .lfps_up(lfps_up), .lfps_dn(lfps_dn),
    .rx_term_det(rx_term_det), .elec_idle(elec_idle), .ss_rate_det(ss_rate_det),
    .aux_wr_valid(aux_wr_valid), .aux_wr_addr(aux_wr_addr), .aux_wr_data(aux_wr_data),
    .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .bias_en_q(bias_en_q), .strap_mode_q(strap_mode_q), .usb_en_q(usb_en_q), .flip_q(flip_q),
    .dp_lane_en_q(dp_lane_en_q), .sbu_q(sbu_q), .eq_q(eq_q), .usb_pstate_q(usb_pstate_q));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    cyc(2);
    chk(reg_rdata_q, e);
  endtask : rd

  task automatic do_reset(input logic [1:0] ms);
    @(posedge clk);
    rst_n <= 1'b0;
    mode_sel_level <= ms;
    cyc(4);
    chk(bias_en_q, 1'b1);
    rst_n <= 1'b1;
  endtask : do_reset

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    rst_n = 1'b0;
    {lfps_up, lfps_dn, rx_term_det, elec_idle, ss_rate_det, reg_wr_en} = 6'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    mode_sel_level = 2'h0;
    upstream_gain_straps = 4'h6;
    downstream_gain_straps = 4'h9;
    display_gain_straps = 4'hc;
    do_reset(2'h0);
    cyc(15);
    chk({bias_en_q, strap_mode_q, usb_en_q, dp_lane_en_q}, 7'h30);
    chk(eq_q, {2'b11, 4'h6, 4'h6, 4'h9, 4'hc});
    chk(usb_pstate_q, U3);
    @(posedge clk);
    lfps_up <= 1'b1;
    lfps_dn <= 1'b1;
    upstream_gain_straps <= 4'h0;
    cyc(8);
    chk({eq_q.up_on, eq_q.dn_on, eq_q.up1}, 6'h06);
    @(posedge clk);
    lfps_up <= 1'b0;
    lfps_dn <= 1'b0;
    u_arlc_pd_model.leave_usb();
    cyc(12);
    chk({usb_en_q, dp_lane_en_q}, 5'h00);
    u_arlc_pd_model.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
    cyc(12);
    chk({usb_en_q, dp_lane_en_q, sbu_q}, 9'h0f9);
    u_arlc_pd_model.aux_write(DPCD_LANE_ADDR, 8'h01);
    u_arlc_pd_model.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
    cyc(12);
    chk({flip_q, dp_lane_en_q, sbu_q}, 9'h1f6);
    rd(SNOOP_REG_OFF, 8'h00);
    u_arlc_pd_model.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
    cyc(40);
    chk({dp_lane_en_q, sbu_q}, 8'h00);
    // Register mode: display without flip, lanes follow snooped writes
    do_reset(2'h2);
    cyc(10);
    chk(strap_mode_q, 1'b0);
    u_arlc_pd_model.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
    wr(CFG_REG_OFF, 8'h02);
    for (int i = 0; i < 3; i++) begin
      u_arlc_pd_model.aux_write(DPCD_LANE_ADDR, lc[i]);
      cyc(3);
      chk({dp_lane_en_q, sbu_q}, {le[i], 4'h9});
      rd(SNOOP_REG_OFF, lc[i]);
    end
    u_arlc_pd_model.aux_write(20'h00102, 8'h01);
    u_arlc_pd_model.aux_write(DPCD_PWR_ADDR, {5'h00, PWR_D3});
    cyc(3);
    chk(dp_lane_en_q, 4'h0);
    rd(SNOOP_REG_OFF, {PWR_D3, 5'h04});
    u_arlc_pd_model.aux_write(DPCD_PWR_ADDR, 8'h01);
    cyc(3);
    chk(dp_lane_en_q, 4'hf);
    wr(CTRL_REG_OFF, 8'h01);
    wr(LANE_REG_OFF, 8'h05);
    wr(SNOOP_REG_OFF, 8'h00);
    wr(DNG_REG_OFF, 8'h03);
    u_arlc_pd_model.aux_write(DPCD_LANE_ADDR, 8'h01);
    cyc(3);
    chk({dp_lane_en_q, eq_q.dn}, 8'h53);
    rd(SNOOP_REG_OFF, 8'h24);
    rd(8'h20, 8'h00);
    // Register override of sideband routing, then display off opens at once
    wr(CFG_REG_OFF, 8'h12);
    cyc(2);
    chk({dp_lane_en_q, sbu_q}, 8'h56);
    wr(CFG_REG_OFF, 8'h01);
    cyc(2);
    chk({usb_en_q, dp_lane_en_q, sbu_q}, 9'h100);
    // Link power state from line conditions
    @(posedge clk);
    rx_term_det <= 1'b1;
    ss_rate_det <= 1'b1;
    cyc(8);
    chk(usb_pstate_q, U0);
    @(posedge clk);
    elec_idle <= 1'b1;
    cyc(6);
    chk(usb_pstate_q, U1);
    cyc(24);
    chk(usb_pstate_q, U2);
    @(posedge clk);
    rx_term_det <= 1'b0;
    cyc(8);
    chk(usb_pstate_q, U3);
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule : arlc_top_tb
